/* File: design/vertical_window_of_interest_ctrl.sv */
/*
 Vertical window of interest controller: preset and active row window,
 software or select-line activation, row readout sequencing.
 Assumes all inputs synchronous to clock and a master that never waits.
*/
// The plain strobed port and the placing of the registers were decided locally.
`timescale 1ns/1ps
module vertical_window_of_interest_ctrl
    import vwoi_pkg::*;
(
    input wire logic clock, // Core clock, 40 MHz
    input wire logic srst, // Synchronous reset, high
    input wire bus_req_t bus, // Register request
    output logic [31:0] rdata, // Read data, cycle after read
    input wire logic external_frame_trigger, // Frame trigger, falling edge
    input wire logic window_select, // Hardware window select level
    output readout_t readout // Row readout control
);

    function automatic logic rows_ok(input row_t first, input row_t last);
        logic ok;
        ok = first >= START_MIN && first <= START_MAX && first[1:0] == 2'b01;
        ok = ok && last >= END_MIN && last <= END_MAX && last[1:0] == 2'b00;
        return ok && last > first;
    endfunction

    function automatic row_t line_cycles(input logic [1:0] sel);
        case (sel)
            LT_MID: return LINE_CYC_MID;
            LT_SLOW: return LINE_CYC_SLOW;
            default: return LINE_CYC_FAST;
        endcase
    endfunction

    ctrl_state_t s;
    ctrl_state_t next_s;
    logic fall;
    logic set_pend;
    logic set_rej;
    logic clr_rej;
    logic apply;
    row_t wr_start;
    row_t wr_end;

    assign fall = s.trig_d & ~external_frame_trigger;
    assign wr_start = bus.wdata[START_LSB +: ROW_W];
    assign wr_end = bus.wdata[END_LSB +: ROW_W];

    always_comb begin
        next_s = s;
        next_s.rdata = 32'h0;
        next_s.frame_done = 1'b0;
        next_s.trig_d = external_frame_trigger;
        set_pend = 1'b0;
        set_rej = 1'b0;
        apply = 1'b0;
        clr_rej = bus.rd && bus.addr == ADDR_STATUS;

        if (bus.wr) begin
            case (bus.addr)
                ADDR_SOURCE: begin
                    if (bus.wdata[1:0] == SRC_SW || bus.wdata[1:0] == SRC_HW) begin
                        next_s.src = bus.wdata[1:0];
                    end
                end
                ADDR_SEQ: begin
                    next_s.seq_sel = bus.wdata[0];
                    // A change in either direction is the trigger
                    if (s.src == SRC_SW && bus.wdata[0] != s.seq_sel) begin
                        set_pend = 1'b1;
                    end
                end
                ADDR_PRESET: begin
                    if (rows_ok(wr_start, wr_end)) begin
                        next_s.pre_start = wr_start;
                        next_s.pre_end = wr_end;
                    end else begin
                        set_rej = 1'b1;
                    end
                end
                ADDR_LINE: begin
                    if (bus.wdata[1:0] != 2'h3) begin
                        next_s.lt_sel = bus.wdata[1:0];
                    end
                end
                default: begin
                end
            endcase
        end

        if (bus.rd) begin
            case (bus.addr)
                ADDR_SOURCE: next_s.rdata = {30'h0, s.src};
                ADDR_SEQ: next_s.rdata = {31'h0, s.seq_sel};
                ADDR_PRESET: begin
                    next_s.rdata[START_LSB +: ROW_W] = s.pre_start;
                    next_s.rdata[END_LSB +: ROW_W] = s.pre_end;
                end
                ADDR_ACTIVE: begin
                    next_s.rdata[START_LSB +: ROW_W] = s.act_start;
                    next_s.rdata[END_LSB +: ROW_W] = s.act_end;
                end
                ADDR_STATUS: begin
                    next_s.rdata[ST_PEND] = s.pend;
                    next_s.rdata[ST_REJECT] = s.reject;
                    next_s.rdata[ST_BUSY] = s.phase != PH_IDLE;
                    next_s.rdata[ST_DISCARD] = s.discard;
                    next_s.rdata[ST_LEVEL] = s.sel_last;
                end
                ADDR_LINE: next_s.rdata = {30'h0, s.lt_sel};
                default: next_s.rdata = 32'h0;
            endcase
        end

        if (fall) begin
            // Level is only looked at on the trigger edge, so glitches between edges are ignored
            next_s.sel_last = window_select;
            if (s.src == SRC_HW && window_select != s.sel_last) begin
                set_pend = 1'b1;
            end
        end

        case (s.phase)
            PH_IDLE: begin
                if (fall) begin
                    // A pending switch waits for a frame boundary, never mid-frame
                    apply = s.pend;
                    next_s.phase = PH_READ;
                    next_s.line_cnt = '0;
                    next_s.discard = s.pend;
                    next_s.frame_valid = !s.pend;
                    if (s.pend) begin
                        next_s.act_start = s.pre_start;
                        next_s.act_end = s.pre_end;
                        next_s.row = s.pre_start;
                    end else begin
                        next_s.row = s.act_start;
                    end
                end
            end
            PH_READ: begin
                if (s.line_cnt == line_cycles(s.lt_sel) - 11'h1) begin
                    next_s.line_cnt = '0;
                    // One overhead line after the last window row
                    if (s.row == s.act_end + 11'h1) begin
                        next_s.phase = PH_DONE;
                        next_s.frame_valid = 1'b0;
                        next_s.frame_done = 1'b1;
                    end else begin
                        next_s.row = s.row + 11'h1;
                    end
                end else begin
                    next_s.line_cnt = s.line_cnt + 11'h1;
                end
            end
            PH_DONE: begin
                next_s.phase = PH_IDLE;
                next_s.discard = 1'b0;
            end
            default: next_s.phase = PH_IDLE;
        endcase

        next_s.row_active = next_s.phase == PH_READ && next_s.row <= next_s.act_end;
        // New events win over the consuming or clearing action in the same cycle
        next_s.pend = (s.pend & ~apply) | set_pend;
        next_s.reject = (s.reject & ~clr_rej) | set_rej;
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            s <= '0;
            s.src <= SRC_SW;
            s.seq_sel <= 1'b0;
            s.lt_sel <= LT_FAST;
            s.pre_start <= FULL_START;
            s.pre_end <= FULL_END;
            s.act_start <= FULL_START;
            s.act_end <= FULL_END;
            s.phase <= PH_IDLE;
        end else begin
            s <= next_s;
        end
    end

    assign rdata = s.rdata;
    assign readout = '{
        row_active: s.row_active,
        row_index: s.row,
        frame_valid: s.frame_valid,
        frame_done: s.frame_done
    };

    // Helper for checking: cycles spent in the readout phase of a frame
    logic [21:0] frame_cyc;
    always_ff @(posedge clock) begin
        if (srst || s.phase == PH_IDLE) begin
            frame_cyc <= 22'h0;
        end else if (s.phase == PH_READ) begin
            frame_cyc <= frame_cyc + 22'h1;
        end
    end

    // All checks share the core clock and all but a_reset_seq_zero are off while reset is held
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (srst);

    a_sw_toggle_pend: assert property (
        bus.wr && bus.addr == ADDR_SEQ && s.src == SRC_SW && bus.wdata[0] != s.seq_sel
        |=> s.pend)
        else $error("software toggle did not set a pending switch");

    a_hw_seq_ignored: assert property (
        bus.wr && bus.addr == ADDR_SEQ && s.src == SRC_HW && !fall
        |=> s.pend == $past(s.pend))
        else $error("sequence write changed pending state in hardware mode");

    a_hw_level_pend: assert property (
        fall && s.src == SRC_HW && window_select != s.sel_last
        |=> s.pend && s.sel_last == $past(window_select))
        else $error("select level change not captured at trigger fall");

    a_bad_rows_kept: assert property (
        bus.wr && bus.addr == ADDR_PRESET && !rows_ok(wr_start, wr_end)
        |=> s.reject && $stable(s.pre_start) && $stable(s.pre_end))
        else $error("illegal window rows were not rejected");

    a_good_rows_load: assert property (
        bus.wr && bus.addr == ADDR_PRESET && rows_ok(wr_start, wr_end)
        |=> s.pre_start == $past(wr_start) && s.pre_end == $past(wr_end))
        else $error("legal window rows were not stored as preset");

    a_apply_discard: assert property (
        fall && s.phase == PH_IDLE && s.pend && !set_pend
        |=> s.act_start == $past(s.pre_start) && s.act_end == $past(s.pre_end)
            && s.discard && !s.frame_valid && !s.pend)
        else $error("switched frame was not discarded");

    a_row_in_window: assert property (
        s.row_active |-> s.row >= s.act_start && s.row <= s.act_end)
        else $error("row read outside active window");

    // Widened before the product: the longest window at the slowest line overflows 11 bits
    a_frame_time: assert property (
        s.phase == PH_READ ##1 s.phase == PH_DONE
        |-> frame_cyc == (22'(s.act_end) - 22'(s.act_start) + 22'h2)
            * 22'(line_cycles(s.lt_sel)))
        else $error("frame readout length is not lines plus one");

    a_reset_seq_zero: assert property (@(posedge clock) disable iff (1'b0)
        srst |=> s.seq_sel == 1'b0 && !s.pend && s.phase == PH_IDLE)
        else $error("reset did not restore sequence value zero");

    // Register side: refused writes must leave stored settings untouched
    a_src_write_kept: assert property (
        bus.wr && bus.addr == ADDR_SOURCE
            && bus.wdata[1:0] != SRC_SW && bus.wdata[1:0] != SRC_HW
        |=> $stable(s.src))
        else $error("unsupported activation source was taken");

    a_src_stored: assert property (
        bus.wr && bus.addr == ADDR_SOURCE
            && (bus.wdata[1:0] == SRC_SW || bus.wdata[1:0] == SRC_HW)
        |=> s.src == $past(bus.wdata[1:0]))
        else $error("supported activation source was not stored");

    a_line_sel_kept: assert property (
        bus.wr && bus.addr == ADDR_LINE && bus.wdata[1:0] == 2'h3
        |=> $stable(s.lt_sel))
        else $error("unsupported line time selection was taken");

    a_seq_stored: assert property (
        bus.wr && bus.addr == ADDR_SEQ
        |=> s.seq_sel == $past(bus.wdata[0]))
        else $error("sequence value write was not stored");

    a_preset_held: assert property (
        !(bus.wr && bus.addr == ADDR_PRESET)
        |=> $stable(s.pre_start) && $stable(s.pre_end))
        else $error("preset window changed without a preset write");

    a_reject_sticky: assert property (
        s.reject && !(bus.rd && bus.addr == ADDR_STATUS)
        |=> s.reject)
        else $error("reject flag cleared without a status read");

    a_reject_read_clear: assert property (
        s.reject && bus.rd && bus.addr == ADDR_STATUS && !bus.wr
        |=> !s.reject && rdata[ST_REJECT])
        else $error("status read did not report and clear the reject flag");

    // Frame side: the window may move only at an idle frame boundary,
    // so that no delivered frame mixes rows of two windows
    a_active_held: assert property (
        !(fall && s.phase == PH_IDLE && s.pend)
        |=> $stable(s.act_start) && $stable(s.act_end))
        else $error("active window changed without an applied switch");

    a_sw_level_ignored: assert property (
        fall && s.src == SRC_SW && !s.pend && !bus.wr
        |=> !s.pend)
        else $error("select line raised a switch in software mode");

    a_hw_steady_level: assert property (
        fall && s.src == SRC_HW && window_select == s.sel_last && !s.pend
        |=> !s.pend && s.sel_last == $past(s.sel_last))
        else $error("unchanged select level raised a pending switch");

    a_valid_frame: assert property (
        fall && s.phase == PH_IDLE && !s.pend
        |=> s.frame_valid && !s.discard && $stable(s.act_start) && $stable(s.act_end))
        else $error("frame without a pending switch was not delivered");

    a_discard_not_valid: assert property (
        s.discard
        |-> !s.frame_valid)
        else $error("discarded frame was flagged as valid");

    a_frame_start: assert property (
        fall && s.phase == PH_IDLE
        |=> s.phase == PH_READ && s.row == s.act_start && s.row_active && s.line_cnt == 11'h0)
        else $error("frame readout did not start at the window start row");

    a_busy_fall_ignored: assert property (
        fall && s.phase == PH_READ
        |=> s.phase != PH_IDLE && $stable(s.act_start) && $stable(s.act_end))
        else $error("trigger fall during readout disturbed the frame");

    a_row_held: assert property (
        s.phase == PH_READ && s.line_cnt != line_cycles(s.lt_sel) - 11'h1
        |=> $stable(s.row) && s.line_cnt == $past(s.line_cnt) + 11'h1)
        else $error("row advanced before a full line time");

    a_done_pulse: assert property (
        s.frame_done
        |=> !s.frame_done && s.phase == PH_IDLE && !s.frame_valid && !s.row_active)
        else $error("frame end marker did not last exactly one cycle");

    c_sw_switch: cover property (
        s.src == SRC_SW && fall && s.phase == PH_IDLE && s.pend);
    c_hw_switch: cover property (
        s.src == SRC_HW && fall && s.phase == PH_IDLE && s.pend);
    c_reject: cover property (s.reject && !$past(s.reject));
    c_frame_done: cover property (s.frame_done && !s.discard);
    c_extra_fall: cover property (fall && s.phase == PH_READ);
endmodule

/* File: include/vwoi_pkg.sv */
/*
 Constants, carriers and state layout for the vertical window control.
 Assumes a 40 MHz core clock and a register master that never waits.
*/
package vwoi_pkg;
    localparam int ROW_W = 11;
    typedef logic [ROW_W-1:0] row_t;

    localparam logic [7:0] ADDR_SOURCE = 8'h00;
    localparam logic [7:0] ADDR_SEQ = 8'h04;
    localparam logic [7:0] ADDR_PRESET = 8'h08;
    localparam logic [7:0] ADDR_ACTIVE = 8'h0c;
    localparam logic [7:0] ADDR_STATUS = 8'h10;
    localparam logic [7:0] ADDR_LINE = 8'h14;

    localparam int START_LSB = 0;
    localparam int END_LSB = 16;
    localparam int ST_PEND = 0;
    localparam int ST_REJECT = 1;
    localparam int ST_BUSY = 2;
    localparam int ST_DISCARD = 3;
    localparam int ST_LEVEL = 4;

    localparam logic [1:0] SRC_SW = 2'h1;
    localparam logic [1:0] SRC_HW = 2'h2;
    localparam logic [1:0] LT_FAST = 2'h0;
    localparam logic [1:0] LT_MID = 2'h1;
    localparam logic [1:0] LT_SLOW = 2'h2;

    localparam row_t START_MIN = 11'h001;
    localparam row_t START_MAX = 11'h6bd;
    localparam row_t END_MIN = 11'h002;
    localparam row_t END_MAX = 11'h6c0;
    localparam row_t FULL_START = 11'h001;
    localparam row_t FULL_END = 11'h6c0;

    localparam real CLOCK_MHZ = 40.0;
    localparam real LINE_US_FAST = 18.5;
    localparam real LINE_US_MID = 37.0;
    localparam real LINE_US_SLOW = 45.6;
    localparam row_t LINE_CYC_FAST = row_t'($rtoi(LINE_US_FAST * CLOCK_MHZ + 0.5));
    localparam row_t LINE_CYC_MID = row_t'($rtoi(LINE_US_MID * CLOCK_MHZ + 0.5));
    localparam row_t LINE_CYC_SLOW = row_t'($rtoi(LINE_US_SLOW * CLOCK_MHZ + 0.5));

    typedef enum logic [1:0] {
        PH_IDLE = 2'b00,
        PH_READ = 2'b01,
        PH_DONE = 2'b11
    } phase_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } bus_req_t;

    typedef struct packed {
        logic row_active;
        row_t row_index;
        logic frame_valid;
        logic frame_done;
    } readout_t;

    typedef struct packed {
        logic [1:0] src;
        logic seq_sel;
        logic sel_last;
        logic trig_d;
        logic pend;
        logic reject;
        logic discard;
        logic [1:0] lt_sel;
        row_t pre_start;
        row_t pre_end;
        row_t act_start;
        row_t act_end;
        phase_t phase;
        row_t row;
        row_t line_cnt;
        logic row_active;
        logic frame_valid;
        logic frame_done;
        logic [31:0] rdata;
    } ctrl_state_t;
endpackage

/* File: test/frame_grabber_model.sv */
/*
 Frame grabber model: drives the frame trigger and the window select line.
 Assumes the bench pulses fire for one cycle at a time, once or twice per frame, and sets want_level.
*/
`timescale 1ns/1ps
module frame_grabber_model (
    input wire logic clock, // Core clock
    input wire logic srst, // Synchronous reset, high
    input wire logic fire, // Request one trigger pulse
    input wire logic want_level, // Requested select level
    output logic external_frame_trigger, // Falls at frame start
    output logic window_select // Window select level
);
    logic [2:0] low_cnt;
    logic [2:0] falls;
    always_ff @(posedge clock) begin
        if (srst) begin
            low_cnt <= 3'h0;
            falls <= 3'h3;
            external_frame_trigger <= 1'b1;
            window_select <= 1'b0;
        end else begin
            if (fire) begin
                low_cnt <= 3'h4;
                if (falls != 3'h7) begin
                    falls <= falls + 3'h1;
                end
            end else if (low_cnt != 3'h0) begin
                low_cnt <= low_cnt - 3'h1;
            end
            external_frame_trigger <= !(fire || low_cnt > 3'h1);
            // Moves only after three falls held, so no sampled fall sees it unsettled
            if (want_level != window_select && falls >= 3'h3 && low_cnt == 3'h0 && !fire) begin
                window_select <= want_level;
                falls <= 3'h0;
            end
        end
    end
endmodule

/* File: test/vertical_window_of_interest_ctrl_test.sv */
/*
 Self-checking bench for the vertical window controller.
 Assumes the frame grabber model beside it and a 40 MHz clock.
*/
`timescale 1ns/1ps
module vertical_window_of_interest_ctrl_test;
    import vwoi_pkg::*;
    typedef struct packed {
        logic any;
        logic valid;
        row_t start;
        logic [31:0] hi;
        logic [31:0] tot;
    } frame_exp_t;
    logic clock = 1'b0;
    logic srst = 1'b1;
    bus_req_t bus = '0;
    logic [31:0] rdata;
    logic fire = 1'b0;
    logic want_level = 1'b0;
    logic trig;
    logic sel;
    readout_t readout;
    logic [31:0] rq[$];
    frame_exp_t fq[$];
    frame_exp_t fe;
    int err_total = 0;
    int n_compared = 0;
    int cyc = 0;
    logic rd_d = 1'b0;
    logic in_frame = 1'b0;
    logic [31:0] hi;
    logic [31:0] tot;
    row_t f_start;
    logic f_valid;
    logic [31:0] lt_cyc[3] = '{32'd740, 32'd1480, 32'd1824};
    logic [31:0] line_len = 32'd740;
    logic [31:0] act = 32'h06c0_0001;
    row_t s;
    logic lev = 1'b0;
    int unsigned lt;

    always #12.5 clock = ~clock;

    vertical_window_of_interest_ctrl uut (.clock(clock), .srst(srst), .bus(bus),
        .rdata(rdata), .external_frame_trigger(trig), .window_select(sel),
        .readout(readout));
    frame_grabber_model grabber (.clock(clock), .srst(srst), .fire(fire),
        .want_level(want_level), .external_frame_trigger(trig), .window_select(sel));

    task automatic results();
        $display("Comparisons %0d, mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clock);
        bus.wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        rq.push_back(exp);
        @(posedge clock);
        bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge clock);
        bus.rd <= 1'b0;
    endtask

    // A second fall in mid-frame must start nothing
    task automatic frame(input logic any, input logic valid, input row_t st,
            input logic [31:0] n, input logic extra);
        int k;
        fq.push_back('{any, valid, st, n * line_len, (n + 32'd1) * line_len});
        @(posedge clock);
        fire <= 1'b1;
        @(posedge clock);
        fire <= 1'b0;
        repeat (50) @(posedge clock);
        fire <= extra;
        @(posedge clock);
        fire <= 1'b0;
        k = 0;
        while (readout.frame_done !== 1'b1 && k < 20000) begin
            @(posedge clock);
            k++;
        end
        @(posedge clock);
    endtask

    always @(posedge clock) begin
        cyc++;
        if (cyc == 100000) begin
            err_total++;
            results();
        end
        rd_d <= bus.rd;
        if (rd_d) begin
            check(rdata, rq.pop_front());
        end
        if (readout.frame_done === 1'b1 && in_frame) begin
            in_frame <= 1'b0;
            fe = fq.pop_front();
            if (!fe.any) begin
                check(32'(f_start), 32'(fe.start));
                check(32'(f_valid), 32'(fe.valid));
                check(hi, fe.hi);
                check(tot, fe.tot);
            end
        end else if (readout.row_active === 1'b1 && !in_frame) begin
            in_frame <= 1'b1;
            f_start <= readout.row_index;
            f_valid <= readout.frame_valid;
            hi <= 32'd1;
            tot <= 32'd1;
        end else if (in_frame) begin
            hi <= hi + 32'(readout.row_active);
            tot <= tot + 32'd1;
        end
    end

    initial begin
        void'($urandom(5145));
        repeat (20) @(posedge clock);
        srst <= 1'b0;
        rd(ADDR_SOURCE, 32'h1);
        rd(ADDR_SEQ, 32'h0);
        rd(ADDR_ACTIVE, act);
        rd(ADDR_STATUS, 32'h0);
        rd(8'h20, 32'h0);
        wr(ADDR_SOURCE, 32'h3);
        rd(ADDR_SOURCE, 32'h1);
        for (int i = 0; i < 3; i++) begin
            s = row_t'(($urandom % 400) * 4 + 2);
            wr(ADDR_PRESET, i == 0 ? {5'h0, 11'h6c0, 5'h0, s} :
                i == 1 ? {5'h0, 11'h007, 5'h0, 11'h001} : {5'h0, 11'h008, 5'h0, 11'h009});
            rd(ADDR_PRESET, act);
            rd(ADDR_STATUS, 32'h1 << ST_REJECT);
        end
        lt = $urandom % 3;
        line_len = lt_cyc[lt];
        wr(ADDR_LINE, 32'(lt));
        wr(ADDR_LINE, 32'h3);
        rd(ADDR_LINE, 32'(lt));
        for (int r = 0; r < 2; r++) begin
            s = row_t'(($urandom % 100) * 4 + 1);
            act = {5'h0, s + 11'h3, 5'h0, s};
            // Row word carries rows only: sequence 0, window 1 and full width are implied
            wr(ADDR_PRESET, act);
            wr(ADDR_SEQ, 32'(r == 0));
            wr(ADDR_SEQ, 32'(r == 0));
            rd(ADDR_STATUS, 32'h1 << ST_PEND);
            frame(1'b0, 1'b0, s, 32'd4, r == 0);
            rd(ADDR_ACTIVE, act);
            frame(1'b0, 1'b1, s, 32'd4, 1'b0);
        end
        line_len = lt_cyc[0];
        wr(ADDR_LINE, 32'h0);
        wr(ADDR_SOURCE, 32'(SRC_HW));
        wr(ADDR_SEQ, 32'h1);
        rd(ADDR_STATUS, 32'h0);
        for (int r = 0; r < 2; r++) begin
            s = row_t'(($urandom % 100) * 4 + 1);
            act = {5'h0, s + 11'h3, 5'h0, s};
            wr(ADDR_PRESET, act);
            lev = !lev;
            want_level <= lev;
            repeat (3) frame(1'b1, 1'b0, s, 32'd4, 1'b0);
            rd(ADDR_ACTIVE, act);
            rd(ADDR_STATUS, 32'(lev) << ST_LEVEL);
            frame(1'b0, 1'b1, s, 32'd4, 1'b0);
        end
        check(32'(fq.size()), 32'h0);
        results();
    end
endmodule
